// *** test/mca_headend.sv ***
// Headend terminal model: timing, descriptors, maps and ranging replies
`timescale 1ns/1ps
`default_nettype none

module mca_headend
    import mca_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic cfg_ok,
    input wire logic [2:0] usable_mask,
    input wire logic [2:0] fail_mask,
    input wire logic [15:0] param_base,
    input wire logic range_go,
    input wire logic [7:0] range_id,
    output logic desc_valid,
    output mca_desc_t desc,
    output logic sync_valid,
    output logic [31:0] sync_ts,
    output logic map_valid,
    output logic [7:0] map_id,
    output logic range_ok,
    output logic range_fail
);
    logic [31:0] tick_r; // Free-running message clock
    logic [1:0] pend_r; // Ranging reply countdown
    logic [1:0] rid_r; // Channel under ranging, minus one
    logic [7:0] uid; // Descriptor channel in turn
    logic [7:0] mid; // Map channel in turn

    // ========================================
    // Message generator
    assign uid = 8'(tick_r[3:2] % 2'd3) + 8'h01;
    assign mid = 8'(tick_r[4:3] % 2'd3) + 8'h01;
    // stand-alone start: sends on its own after reset
    // silent headend: no descriptor, sync or map without config; ranging replies still sent
    // periodic messages: fixed periods, to every modem
    // every channel: descriptors rotate over ids 1 to 3
    always_ff @(posedge clk) begin
        tick_r <= rstn ? tick_r + 32'h1 : 32'h0;
        desc_valid <= rstn && cfg_ok && tick_r[1:0] == 2'h0;
        sync_valid <= rstn && cfg_ok && tick_r[2:0] == 3'h5;
        map_valid <= rstn && cfg_ok && tick_r[2:0] == 3'h2;
        // Descriptor and timestamp change every cycle while not qualified; map id holds its inverse
        if (tick_r[1:0] == 2'h0) begin
            desc <= {uid, usable_mask[uid[1:0] - 2'h1], param_base ^ {8'h00, uid}};
        end else begin
            desc <= ~desc;
        end
        sync_ts <= (tick_r[2:0] == 3'h5) ? tick_r : ~tick_r;
        map_id <= (tick_r[2:0] == 3'h2) ? mid : ~mid;
    end

    // ========================================
    // Ranging reply three cycles after the request
    always_ff @(posedge clk) begin
        range_ok <= 1'b0;
        range_fail <= 1'b0;
        if (!rstn) begin
            pend_r <= 2'h0;
        end else if (range_go) begin
            pend_r <= 2'h3;
            rid_r <= range_id[1:0] - 2'h1;
        end else if (pend_r != 2'h0) begin
            pend_r <= pend_r - 2'h1;
            if (pend_r == 2'h1) begin
                range_ok <= !fail_mask[rid_r];
                range_fail <= fail_mask[rid_r];
            end
        end
    end
endmodule : mca_headend

`default_nettype wire

// *** test/mca_seq_tb.sv ***
// Self-checking bench of the channel acquisition sequencer
`timescale 1ns/1ps
`default_nettype none

module mca_seq_tb;
    import mca_pkg::*;
    localparam logic [47:0] MAC = 48'h0a_1b_2c_3d_4e_5f; // Arbitrary value
    localparam int LIMIT = 5000; // Watchdog ceiling in cycles
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    logic sig_lost = 1'b0;
    logic st_valid = 1'b0;
    logic cfg_ok = 1'b1;
    logic [7:0] st_chan = 8'h00;
    logic [7:0] good_ch = 8'h00;
    logic [2:0] usable = 3'b110;
    logic [2:0] fail = 3'b010;
    logic [15:0] base = 16'h0000;
    mca_ds_lock_t lock_val = '0;
    mca_ds_lock_t ds_lock = '0;
    logic desc_v, sync_v, map_v, r_ok, r_fail;
    mca_desc_t desc;
    logic [31:0] sync_ts, mts, last_ts;
    logic [7:0] map_id, ds_chan, us_id, last_map, s;
    logic tune, scanning, ds_valid, tx_ok, r_start, r_act, done;
    logic [15:0] us_par;
    logic [47:0] mac;
    logic [31:0] seed = 32'h0001_3aca;
    int n_rng = 0;
    int cyc = 0;
    int n0;
    int miscompares = 0;
    int n_tests = 0;

    mca_seq #(.LOCK_TO_CYC(40), .DESC_TO_CYC(40), .SYNC_TO_CYC(40), .MAP_TO_CYC(40),
        .RANGE_TO_CYC(40), .MAC_ADDR(MAC)) dut (
        .CORE_CLK(clk), .RSTN(rstn), .START(start), .SIGNAL_LOST(sig_lost),
        .STORED_CHAN(st_chan), .STORED_VALID(st_valid), .DS_LOCK(ds_lock),
        .DESC_VALID(desc_v), .DESC(desc), .SYNC_VALID(sync_v), .SYNC_TIMESTAMP(sync_ts),
        .MAP_VALID(map_v), .MAP_CHAN_ID(map_id), .RANGE_OK(r_ok), .RANGE_FAIL(r_fail),
        .DS_CHAN(ds_chan), .TUNE(tune), .SCANNING(scanning), .DS_VALID(ds_valid),
        .US_CHAN_ID(us_id), .US_PARAMS(us_par), .MINISLOT_TS(mts), .TX_ALLOWED(tx_ok),
        .RANGE_START(r_start), .RANGING_ACTIVE(r_act), .INIT_DONE(done),
        .MAC_ADDRESS(mac));

    mca_headend hdr (
        .clk(clk), .rstn(rstn), .cfg_ok(cfg_ok), .usable_mask(usable), .fail_mask(fail),
        .param_base(base), .range_go(r_start), .range_id(us_id), .desc_valid(desc_v),
        .desc(desc), .sync_valid(sync_v), .sync_ts(sync_ts), .map_valid(map_v),
        .map_id(map_id), .range_ok(r_ok), .range_fail(r_fail));

    // ========================================
    // Clock of 40 ns
    initial begin
        forever #20 clk = ~clk;
    end

    // Receiver locks follow the tuned channel
    always @(posedge clk) begin
        ds_lock <= (ds_chan == good_ch) ? lock_val : '0;
    end

    // Monitor of messages, ranging requests and the watchdog
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sync_v) last_ts <= sync_ts;
        if (map_v) last_map <= map_id;
        if (r_start === 1'b1) n_rng <= n_rng + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            end_of_test();
        end
    end

    // ========================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction : xs

    // Next channel of the scan, wrapping at the band top
    function automatic logic [7:0] nxt(input logic [7:0] c);
        return (c == 8'h7f) ? 8'h00 : c + 8'h01;
    endfunction : nxt

    task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Waits on falling edges for tune, valid, ranging start or done
    task automatic wt(input int which, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge clk);
            if ((which == 0 && tune === 1'b1) || (which == 1 && ds_valid === 1'b1) ||
                (which == 2 && r_start === 1'b1) || (which == 3 && done === 1'b1)) begin
                return;
            end
        end
        chk("wait", 48'h0, 48'h1);
    endtask : wt

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // ========================================
    // Main sequence
    initial begin
        seed = xs(seed);
        base <= seed[15:0];
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("init_done", done, 1'b0);
        chk("tx_allowed", tx_ok, 1'b0);
        chk("mac", mac, MAC);
        @(posedge clk);
        rstn <= 1'b1;
        // Stored channel at band top, sync recognition missing
        @(posedge clk);
        st_valid <= 1'b1;
        st_chan <= 8'h7f;
        good_ch <= 8'h7f;
        lock_val <= 4'he;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wt(0, 20);
        chk("ds_chan", ds_chan, 8'h7f);
        repeat (15) @(negedge clk);
        chk("ds_valid", ds_valid, 1'b0);
        wt(0, 200);
        chk("ds_chan", ds_chan, 8'h00);
        chk("scanning", scanning, 1'b1);
        good_ch <= 8'h01;
        lock_val <= 4'hf;
        wt(0, 200);
        chk("ds_chan", ds_chan, 8'h01);
        wt(1, 50);
        chk("tx_allowed", tx_ok, 1'b0);
        // Id 1 unusable, id 2 fails ranging, id 3 succeeds
        wt(2, 300);
        chk("us_id", us_id, 8'h02);
        chk("us_params", us_par, base ^ 16'h0002);
        chk("minislot", mts, last_ts);
        chk("map_id", last_map, 8'h02);
        chk("tx_allowed", tx_ok, 1'b1);
        chk("ranging", r_act, 1'b1);
        chk("scanning", scanning, 1'b0);
        wt(2, 300);
        chk("us_id", us_id, 8'h03);
        wt(3, 50);
        chk("ranges", n_rng, 2);
        // Signal loss with a silent headend on the stored channel
        @(posedge clk);
        seed = xs(seed);
        s = {1'b0, seed[6:0]};
        st_chan <= s;
        good_ch <= s;
        cfg_ok <= 1'b0;
        sig_lost <= 1'b1;
        @(posedge clk);
        sig_lost <= 1'b0;
        wt(0, 20);
        chk("ds_chan", ds_chan, s);
        chk("init_done", done, 1'b0);
        chk("tx_allowed", tx_ok, 1'b0);
        wt(0, 300);
        chk("ds_chan", ds_chan, nxt(s));
        // Every channel usable, every ranging attempt fails
        @(posedge clk);
        good_ch <= nxt(s);
        cfg_ok <= 1'b1;
        usable <= 3'b111;
        fail <= 3'b111;
        n0 = n_rng;
        wt(0, 900);
        chk("ds_chan", ds_chan, nxt(nxt(s)));
        chk("ranges", n_rng - n0, 3);
        end_of_test();
    end
endmodule : mca_seq_tb

`default_nettype wire

// *** verilog/mca_defs.svh ***
// Constants of the modem channel acquisition sequencer
`ifndef MCA_DEFS_SVH
`define MCA_DEFS_SVH

// ==========================================================
// Band plan
`define MCA_CHAN_STEP_KHZ 6000
`define MCA_NUM_DS_CHAN 8'd128
`define MCA_FIRST_DS_CHAN 8'h00
`define MCA_LAST_DS_CHAN 8'h7f

// ==========================================================
// Upstream channel set
`define MCA_NUM_US_ID 8

// ==========================================================
// Phase timeouts in microseconds, default values
`define MCA_CLK_MHZ 25
`define MCA_LOCK_TO_US 2000
`define MCA_DESC_TO_US 2000
`define MCA_SYNC_TO_US 1000
`define MCA_MAP_TO_US 1000
`define MCA_RANGE_TO_US 1000

`endif

// *** verilog/mca_pkg.sv ***
// Types of the modem channel acquisition sequencer
`default_nettype none
package mca_pkg;

    // ==========================================================
    // Sequencer states
    typedef enum logic [3:0] {
        MCA_IDLE,
        MCA_RETRY_STORED,
        MCA_SCAN_TUNE,
        MCA_SCAN_WAIT,
        MCA_COLLECT_DESC,
        MCA_PICK_US,
        MCA_WAIT_SYNC,
        MCA_WAIT_MAP,
        MCA_RANGING,
        MCA_DONE
    } mca_state_t;

    // Downstream lock indications from the receiver
    typedef struct packed {
        logic qam_lock;
        logic fec_lock;
        logic mpeg_lock;
        logic sync_seen;
    } mca_ds_lock_t;

    // One received upstream channel descriptor
    typedef struct packed {
        logic [7:0] chan_id;
        logic usable;
        logic [15:0] params;
    } mca_desc_t;

endpackage : mca_pkg

`default_nettype wire

// *** verilog/mca_seq.sv ***
// Channel acquisition sequencer of a subscriber modem
`timescale 1ns/1ps
`default_nettype none
`include "mca_defs.svh"

// Notes on behaviour
// - Initialization phases run in fixed order
// - Fixed unique 48-bit address identifies modem
// - First retry the stored downstream channel
// - Else scan band in 6 MHz steps
// - Valid needs all locks plus timing messages
// - Show scan in progress to user
// - Await descriptor, judge channel usability
// - Collect distinct descriptor IDs into set
// - No usable channel by timeout: rescan
// - Unsuitable channel: try next identifier
// - Take parameters, latch timestamp from timing
// - Existing time reference skips timing wait
// - Transmit only after map, within grants
// - Range once; failure selects next identifier
// - All identifiers failed: resume downstream scan
// - Map timeout skips an identifier unranged; sync timeout rescans
module mca_seq
    import mca_pkg::*;
#(
    parameter int LOCK_TO_CYC = `MCA_LOCK_TO_US * `MCA_CLK_MHZ,
    parameter int DESC_TO_CYC = `MCA_DESC_TO_US * `MCA_CLK_MHZ,
    parameter int SYNC_TO_CYC = `MCA_SYNC_TO_US * `MCA_CLK_MHZ,
    parameter int MAP_TO_CYC = `MCA_MAP_TO_US * `MCA_CLK_MHZ,
    parameter int RANGE_TO_CYC = `MCA_RANGE_TO_US * `MCA_CLK_MHZ,
    parameter logic [47:0] MAC_ADDR = 48'h02_00_00_00_00_01  // Arbitrary value
) (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic START,
    input wire logic SIGNAL_LOST,
    input wire logic [7:0] STORED_CHAN,
    input wire logic STORED_VALID,
    input wire mca_ds_lock_t DS_LOCK,
    input wire logic DESC_VALID,
    input wire mca_desc_t DESC,
    input wire logic SYNC_VALID,
    input wire logic [31:0] SYNC_TIMESTAMP,
    input wire logic MAP_VALID,
    input wire logic [7:0] MAP_CHAN_ID,
    input wire logic RANGE_OK,
    input wire logic RANGE_FAIL,
    output logic [7:0] DS_CHAN,
    output logic TUNE,
    output logic SCANNING,
    output logic DS_VALID,
    output logic [7:0] US_CHAN_ID,
    output logic [15:0] US_PARAMS,
    output logic [31:0] MINISLOT_TS,
    output logic TX_ALLOWED,
    output logic RANGE_START,
    output logic RANGING_ACTIVE,
    output logic INIT_DONE,
    output logic [47:0] MAC_ADDRESS
);

    // ==========================================================
    // Input synchronisers for the pin-level lock and loss flags
    logic [3:0] lock_s1_r;  // First stage, read only by second
    logic [3:0] lock_s2_r;  // Second stage
    logic lost_s1_r;
    logic lost_s2_r;

    // Register the asynchronous lock and loss levels
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            lock_s1_r <= 4'h0;
            lock_s2_r <= 4'h0;
            lost_s1_r <= 1'b0;
            lost_s2_r <= 1'b0;
        end else begin
            lock_s1_r <= DS_LOCK;
            lock_s2_r <= lock_s1_r;
            lost_s1_r <= SIGNAL_LOST;
            lost_s2_r <= lost_s1_r;
        end
    end

    logic ds_ok;
    assign ds_ok = &lock_s2_r;

    // ==========================================================
    // Sequencer state
    mca_state_t state_r, state_nxt;
    logic [7:0] ds_chan_r, ds_chan_nxt;         // Tuned downstream channel
    logic [7:0] id_set_r [`MCA_NUM_US_ID];       // Collected channel IDs
    logic [7:0] id_set_nxt [`MCA_NUM_US_ID];
    logic [`MCA_NUM_US_ID-1:0] id_use_r, id_use_nxt;  // Usable flags per slot
    logic [`MCA_NUM_US_ID-1:0] id_vld_r, id_vld_nxt;  // Slot occupied
    logic [15:0] par_set_r [`MCA_NUM_US_ID];     // Parameters per slot
    logic [15:0] par_set_nxt [`MCA_NUM_US_ID];
    logic [2:0] pick_r, pick_nxt;                // Candidate slot
    logic [7:0] us_id_r, us_id_nxt;
    logic [15:0] us_par_r, us_par_nxt;
    logic [31:0] ts_r, ts_nxt;
    logic ts_have_r, ts_have_nxt;                // Time reference held
    logic tx_r, tx_nxt;
    logic rs_r, rs_nxt;                          // Ranging start pulse
    logic tune_r, tune_nxt;
    logic done_r, done_nxt;
    logic tmr_load;
    logic [23:0] tmr_count;
    logic tmr_exp;
    logic hit;                                   // Descriptor ID already held
    logic [2:0] free_slot;
    logic has_free;
    logic has_use;
    logic [2:0] next_use;
    logic found_next;

    mca_timer #(.WIDTH(24)) u_timer (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .load(tmr_load),
        .count(tmr_count),
        .expired(tmr_exp)
    );

    // Search helpers over the identifier set
    always_comb begin
        hit = 1'b0;
        has_free = 1'b0;
        free_slot = 3'h0;
        has_use = |id_use_r;
        found_next = 1'b0;
        next_use = 3'h0;
        for (int i = 0; i < `MCA_NUM_US_ID; i++) begin
            if (id_vld_r[i] && id_set_r[i] == DESC.chan_id) begin
                hit = 1'b1;
            end
            if (!id_vld_r[i] && !has_free) begin
                has_free = 1'b1;
                free_slot = 3'(i);
            end
            if (id_use_r[i] && !found_next && 3'(i) > pick_r) begin
                found_next = 1'b1;
                next_use = 3'(i);
            end
        end
    end

    // Next-state and datapath
    always_comb begin
        state_nxt = state_r;
        ds_chan_nxt = ds_chan_r;
        id_set_nxt = id_set_r;
        id_use_nxt = id_use_r;
        id_vld_nxt = id_vld_r;
        par_set_nxt = par_set_r;
        pick_nxt = pick_r;
        us_id_nxt = us_id_r;
        us_par_nxt = us_par_r;
        ts_nxt = ts_r;
        ts_have_nxt = ts_have_r;
        tx_nxt = tx_r;
        rs_nxt = 1'b0;
        tune_nxt = 1'b0;
        done_nxt = done_r;
        tmr_load = 1'b0;
        tmr_count = 24'(LOCK_TO_CYC);
        // Any state: a timing message refreshes the reference
        if (SYNC_VALID && ds_ok) begin
            ts_nxt = SYNC_TIMESTAMP;
            ts_have_nxt = 1'b1;
        end
        case (state_r)
            MCA_IDLE: begin
                if (START) begin
                    if (STORED_VALID) begin
                        ds_chan_nxt = STORED_CHAN;
                        state_nxt = MCA_RETRY_STORED;
                    end else begin
                        ds_chan_nxt = `MCA_FIRST_DS_CHAN;
                        state_nxt = MCA_SCAN_WAIT;
                    end
                    tune_nxt = 1'b1;
                    tmr_load = 1'b1;
                end
            end
            MCA_RETRY_STORED, MCA_SCAN_WAIT: begin
                if (ds_ok) begin
                    id_vld_nxt = '0;
                    id_use_nxt = '0;
                    state_nxt = MCA_COLLECT_DESC;
                    tmr_load = 1'b1;
                    tmr_count = 24'(DESC_TO_CYC);
                end else if (tmr_exp) begin
                    state_nxt = MCA_SCAN_TUNE;
                end
            end
            MCA_SCAN_TUNE: begin
                if (state_r == MCA_SCAN_TUNE && ds_chan_r >= `MCA_LAST_DS_CHAN) begin
                    ds_chan_nxt = `MCA_FIRST_DS_CHAN;
                end else begin
                    ds_chan_nxt = ds_chan_r + 8'h01;
                end
                ts_have_nxt = 1'b0;
                tune_nxt = 1'b1;
                tmr_load = 1'b1;
                state_nxt = MCA_SCAN_WAIT;
            end
            MCA_COLLECT_DESC: begin
                if (DESC_VALID && !hit && has_free) begin
                    id_set_nxt[free_slot] = DESC.chan_id;
                    par_set_nxt[free_slot] = DESC.params;
                    id_vld_nxt[free_slot] = 1'b1;
                    id_use_nxt[free_slot] = DESC.usable;
                end
                if (tmr_exp) begin
                    pick_nxt = 3'h0;
                    state_nxt = has_use ? MCA_PICK_US : MCA_SCAN_TUNE;
                end
            end
            MCA_PICK_US: begin
                if (!id_use_r[pick_r]) begin
                    if (found_next) begin
                        pick_nxt = next_use;
                    end else begin
                        state_nxt = MCA_SCAN_TUNE;
                    end
                end else begin
                    us_id_nxt = id_set_r[pick_r];
                    us_par_nxt = par_set_r[pick_r];
                    tmr_load = 1'b1;
                    if (ts_have_r) begin
                        tmr_count = 24'(MAP_TO_CYC);
                        state_nxt = MCA_WAIT_MAP;
                    end else begin
                        tmr_count = 24'(SYNC_TO_CYC);
                        state_nxt = MCA_WAIT_SYNC;
                    end
                end
            end
            MCA_WAIT_SYNC: begin
                if (SYNC_VALID && ds_ok) begin
                    tmr_load = 1'b1;
                    tmr_count = 24'(MAP_TO_CYC);
                    state_nxt = MCA_WAIT_MAP;
                end else if (tmr_exp) begin
                    state_nxt = MCA_SCAN_TUNE;
                end
            end
            MCA_WAIT_MAP: begin
                if (MAP_VALID && MAP_CHAN_ID == us_id_r) begin
                    tx_nxt = 1'b1;
                    rs_nxt = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = 24'(RANGE_TO_CYC);
                    state_nxt = MCA_RANGING;
                end else if (tmr_exp) begin
                    // no map: try the next usable identifier
                    if (found_next) begin
                        pick_nxt = next_use;
                        state_nxt = MCA_PICK_US;
                    end else begin
                        state_nxt = MCA_SCAN_TUNE;
                    end
                end
            end
            MCA_RANGING: begin
                if (RANGE_OK) begin
                    done_nxt = 1'b1;
                    state_nxt = MCA_DONE;
                end else if (RANGE_FAIL || tmr_exp) begin
                    tx_nxt = 1'b0;
                    if (found_next) begin
                        pick_nxt = next_use;
                        state_nxt = MCA_PICK_US;
                    end else begin
                        state_nxt = MCA_SCAN_TUNE;
                    end
                end
            end
            MCA_DONE: begin
                done_nxt = 1'b1;
            end
            default: begin
                state_nxt = MCA_IDLE;
            end
        endcase
        // signal loss restarts from stored channel, or rescans when none is stored
        if (lost_s2_r && state_r != MCA_IDLE) begin
            state_nxt = STORED_VALID ? MCA_RETRY_STORED : MCA_SCAN_TUNE;
            ds_chan_nxt = STORED_VALID ? STORED_CHAN : ds_chan_r;
            tune_nxt = STORED_VALID;
            tmr_load = 1'b1;
            tmr_count = 24'(LOCK_TO_CYC);
            tx_nxt = 1'b0;
            done_nxt = 1'b0;
            ts_have_nxt = 1'b0;
        end
    end

    // Register the sequencer
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            state_r <= MCA_IDLE;
            ds_chan_r <= 8'h00;
            id_use_r <= '0;
            id_vld_r <= '0;
            pick_r <= 3'h0;
            us_id_r <= 8'h00;
            us_par_r <= 16'h0000;
            ts_r <= 32'h0000_0000;
            ts_have_r <= 1'b0;
            tx_r <= 1'b0;
            rs_r <= 1'b0;
            tune_r <= 1'b0;
            done_r <= 1'b0;
            for (int i = 0; i < `MCA_NUM_US_ID; i++) begin
                id_set_r[i] <= 8'h00;
                par_set_r[i] <= 16'h0000;
            end
        end else begin
            state_r <= state_nxt;
            ds_chan_r <= ds_chan_nxt;
            id_set_r <= id_set_nxt;
            par_set_r <= par_set_nxt;
            id_use_r <= id_use_nxt;
            id_vld_r <= id_vld_nxt;
            pick_r <= pick_nxt;
            us_id_r <= us_id_nxt;
            us_par_r <= us_par_nxt;
            ts_r <= ts_nxt;
            ts_have_r <= ts_have_nxt;
            tx_r <= tx_nxt;
            rs_r <= rs_nxt;
            tune_r <= tune_nxt;
            done_r <= done_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign DS_CHAN = ds_chan_r;
    assign TUNE = tune_r;
    assign SCANNING = (state_r == MCA_SCAN_TUNE) || (state_r == MCA_SCAN_WAIT);
    assign DS_VALID = ds_ok && (state_r != MCA_IDLE);
    assign US_CHAN_ID = us_id_r;
    assign US_PARAMS = us_par_r;
    assign MINISLOT_TS = ts_r;
    assign TX_ALLOWED = tx_r;
    assign RANGE_START = rs_r;
    assign RANGING_ACTIVE = (state_r == MCA_RANGING);
    assign INIT_DONE = done_r;
    assign MAC_ADDRESS = MAC_ADDR;

    // ==========================================================
    // Checks
    sequence s_map_hit;
        MAP_VALID && MAP_CHAN_ID == us_id_r && state_r == MCA_WAIT_MAP && !lost_s2_r;
    endsequence

    sequence s_range_go;
        RANGE_START && TX_ALLOWED;
    endsequence

    a_map_then_tx: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        s_map_hit |=> s_range_go) else $error("Map did not start ranging");

    a_tx_needs_map: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        $rose(TX_ALLOWED) |-> $past(MAP_VALID)) else $error("Transmit without map");

    a_valid_needs_lock: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        DS_VALID |-> $past(DS_LOCK, 2) == 4'hf) else $error("Downstream valid without locks");

    a_scan_flag: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        state_r == MCA_SCAN_TUNE && !lost_s2_r |=> SCANNING && TUNE)
        else $error("Scan flag missing");

    a_scan_wrap: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        state_r == MCA_SCAN_TUNE && ds_chan_r == `MCA_LAST_DS_CHAN && !lost_s2_r
        |=> ds_chan_r == `MCA_FIRST_DS_CHAN) else $error("Scan did not wrap");

    a_stored_first: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        state_r == MCA_IDLE && START && STORED_VALID
        |=> state_r == MCA_RETRY_STORED && ds_chan_r == $past(STORED_CHAN))
        else $error("Stored channel not tried first");

    a_desc_timeout: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        state_r == MCA_COLLECT_DESC && tmr_exp && !has_use && !lost_s2_r
        |=> state_r == MCA_SCAN_TUNE) else $error("No rescan after timeout");

    a_skip_sync: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        state_r == MCA_PICK_US && id_use_r[pick_r] && ts_have_r && !lost_s2_r
        |=> state_r == MCA_WAIT_MAP) else $error("Timing wait not skipped");

    a_range_retry: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        state_r == MCA_RANGING && RANGE_FAIL && !RANGE_OK && found_next && !lost_s2_r
        |=> state_r == MCA_PICK_US && pick_r == $past(next_use))
        else $error("Next identifier not selected");

    a_mac_fixed: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        MAC_ADDRESS == $past(MAC_ADDRESS)) else $error("Address changed");

endmodule : mca_seq

`default_nettype wire

// *** verilog/mca_timer.sv ***
// Down-counting phase timer with load and expiry flag
`timescale 1ns/1ps
`default_nettype none

module mca_timer #(
    parameter int WIDTH = 24
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic expired
);

    // Remaining cycles
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    // Next count: reload, or step down to zero
    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = count;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Register the count
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign expired = (cnt_r == '0) && !load;

endmodule : mca_timer

`default_nettype wire
